// file: hw/tpe_pkg.sv
// Purpose: shared constants and types of the timer prescale and event count block
// Assumes: byte addresses on an 8-bit AXI4-Lite address, one word per register
// Notes: mode codes follow the two-bit mode field of the timer mode register
package tpe_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_SYS_CFG = 8'h00;
  localparam logic [7:0] ADDR_TMR_MODE = 8'h04;
  localparam logic [7:0] ADDR_TMR_CTRL = 8'h08;
  localparam logic [7:0] ADDR_STATUS = 8'h0c;
  localparam logic [7:0] ADDR_COUNT0 = 8'h10;
  localparam logic [7:0] ADDR_RELOAD0 = 8'h1c;
  localparam logic [7:0] ADDR_LAST = 8'h24;
  localparam logic [7:0] ADDR_STRIDE = 8'h04;
  // values after reset
  localparam logic [3:0] SYS_CFG_RESET = 4'h0;
  localparam logic [7:0] TMR_MODE_RESET = 8'h00;
  localparam logic [7:0] TMR_CTRL_RESET = 8'h00;
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  // prescale selection codes, 2'h3 reserved
  localparam logic [1:0] PSC_DIV4 = 2'h0;
  localparam logic [1:0] PSC_DIV16 = 2'h1;
  localparam logic [1:0] PSC_DIV64 = 2'h2;
  localparam int unsigned DIV4 = 4;
  localparam int unsigned DIV16 = 16;
  localparam int unsigned DIV64 = 64;
  localparam logic [5:0] TERM_DIV4 = 6'(DIV4 - 1);
  localparam logic [5:0] TERM_DIV16 = 6'(DIV16 - 1);
  localparam logic [5:0] TERM_DIV64 = 6'(DIV64 - 1);
  // count pins are sampled once every this many oscillator cycles
  localparam int unsigned SAMPLE_CYCLES = 2;
  // timer operating modes
  localparam logic [1:0] MODE_RELOAD16 = 2'h0;
  localparam logic [1:0] MODE_FREE16 = 2'h1;
  localparam logic [1:0] MODE_RELOAD8 = 2'h2;
  // bus answers
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // per-timer mode nibble
  typedef struct packed {
    logic gate;
    logic count_mode;
    logic [1:0] mode;
  } tpe_mode_type;
  // timer control byte
  typedef struct packed {
    logic [2:0] wave_en;
    logic count_down;
    logic count_mode2;
    logic [2:0] run;
  } tpe_ctrl_type;
  // system configuration nibble
  typedef struct packed {
    logic [1:0] prescale;
    logic compat;
    logic page_zero;
  } tpe_cfg_type;
endpackage : tpe_pkg

// file: hw/tpe_prescaler.sv
// Purpose: divides the oscillator into the shared timer base tick
// Assumes: aclk is the oscillator
// Notes: the tick is a one-cycle pulse from a flip-flop
`timescale 1ns/1ps
module tpe_prescaler
  import tpe_pkg::*;
#(
  parameter int unsigned DIV_W = 6
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [1:0] prescale_select,
  output logic timer_base_clock
);
  logic [DIV_W-1:0] div_count;
  logic [DIV_W-1:0] term;

  // refuse a divider too narrow for the largest ratio
  if ((2 ** DIV_W) < DIV64) begin : g_bad_width
    $error("prescaler divider too narrow");
  end

  // terminal count per selection, reserved code behaves as the largest ratio
  always_comb begin
    case (prescale_select)
      PSC_DIV4: term = DIV_W'(TERM_DIV4); // see RULE15
      PSC_DIV16: term = DIV_W'(TERM_DIV16); // see RULE15
      default: term = DIV_W'(TERM_DIV64); // see RULE15
    endcase
  end

  // free running divide counter
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= '0;
    end else if (div_count >= term) begin
      div_count <= '0; // see RULE5
    end else begin
      div_count <= div_count + DIV_W'(1);
    end
  end

  // one tick per division period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_base_clock <= 1'b0;
    end else begin
      timer_base_clock <= (div_count >= term); // see RULE5
    end
  end
endmodule : tpe_prescaler

// file: hw/tpe_event_sampler.sv
// Purpose: finds falling edges on external count pins
// Assumes: pins are asynchronous to aclk
// Notes: pins are sampled every second cycle after a two-flop synchroniser
`timescale 1ns/1ps
module tpe_event_sampler
  import tpe_pkg::*;
#(
  parameter int unsigned N_PIN = 3
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [N_PIN-1:0] count_input_pin,
  output logic [N_PIN-1:0] fall
);
  logic phase;

  // refuse shapes the sampler cannot serve
  if (N_PIN < 1 || SAMPLE_CYCLES != 2) begin : g_bad_shape
    $error("event sampler shape not supported");
  end

  // sample strobe every two cycles
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase; // see RULE9
    end
  end

  for (genvar gi = 0; gi < N_PIN; gi++) begin : g_pin
    logic meta;
    logic sync;
    logic sample;
    // two-flop synchroniser
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        meta <= 1'b0;
        sync <= 1'b0;
      end else begin
        meta <= count_input_pin[gi];
        sync <= meta;
      end
    end
    // each level must last two cycles to be seen by this sample, see RULE10
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        sample <= 1'b0;
        fall[gi] <= 1'b0;
      end else if (phase) begin
        sample <= sync; // see RULE9
        fall[gi] <= sample && !sync; // see RULE8
      end else begin
        fall[gi] <= 1'b0;
      end
    end
  end
endmodule : tpe_event_sampler

// file: hw/tpe_timer_top.sv
// Purpose: three 16-bit timer/counters with a shared prescaled base and AXI4-Lite registers
// Assumes: aclk is the oscillator, count and gate pins are asynchronous
// Notes: timer 2 has no gate pin and counts up or down
// Summary of operation
// RULE1: timers 0, 1 and up/down timer 2
// RULE2: each timer selects timer or event counting
// RULE3: counts advance by one per qualifying tick
// RULE4: count reads never disturb counting
// RULE5: base clock is osc over 4, 16, 64
// RULE6: one base tick for all timers, watchdog
// RULE7: central base tick feeds every timer use
// RULE8: event mode counts falling count pin edges
// RULE9: count pins sampled every two cycles
// RULE10: source holds each level two cycles
// RULE11: overflow flags, toggle outputs, interval measurement
// RULE12: timers 0, 1 have four modes each; the code has three, code 3 counts as MODE_FREE16
// RULE13: select clear uses base, set uses pin
// RULE14: gate enable requires gate pin high too
// RULE15: prescale codes 00, 01, 10; 11 reserved
//
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module tpe_timer_top
  import tpe_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [2:0] count_input_pin,
  input wire logic [1:0] external_interrupt_pin,
  output logic timer_base_clock,
  output logic [2:0] timer_irq,
  output logic [2:0] timer_wave_out
);
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [7:0] rd_addr;
  logic [31:0] next_rdata;
  tpe_cfg_type system_config_reg;
  tpe_mode_type [1:0] timer_mode_reg;
  tpe_ctrl_type timer_control_reg;
  logic [1:0] gate_meta;
  logic [1:0] gate_sync;
  logic [2:0] fall;

  // word address decode
  function automatic logic is_mapped(input logic [7:0] a);
    return (a[1:0] == 2'h0) && (a <= ADDR_LAST);
  endfunction : is_mapped

  // shared base tick, also the watchdog tick
  tpe_prescaler #(
    .DIV_W(6)
  ) u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .prescale_select(system_config_reg.prescale),
    .timer_base_clock(timer_base_clock) // see RULE7
  );

  // falling edge finder for the count pins
  tpe_event_sampler #(
    .N_PIN(3)
  ) u_sampler (
    .aclk(aclk),
    .aresetn(aresetn),
    .count_input_pin(count_input_pin),
    .fall(fall)
  );

  // write address and data taken in either order
  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign wr_en = aw_held && w_held && !s_axi_bvalid;
  assign wr_addr = aw_addr;

  // write address holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (wr_en) begin
      aw_held <= 1'b0;
    end
  end

  // write data holding
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (wr_en) begin
      w_held <= 1'b0;
    end
  end

  // write response, unmapped answers slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else if (wr_en) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= is_mapped(wr_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // configuration registers, byte lane 0
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      system_config_reg <= SYS_CFG_RESET;
      timer_mode_reg <= TMR_MODE_RESET;
      timer_control_reg <= TMR_CTRL_RESET;
    end else if (wr_en && w_strb[0]) begin
      if (wr_addr == ADDR_SYS_CFG) begin
        system_config_reg <= w_data[3:0]; // see RULE5
      end
      if (wr_addr == ADDR_TMR_MODE) begin
        timer_mode_reg <= w_data[7:0]; // see RULE12
      end
      if (wr_addr == ADDR_TMR_CTRL) begin
        timer_control_reg <= w_data[7:0]; // see RULE2
      end
    end
  end

  // gate pin synchroniser
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gate_meta <= 2'h0;
      gate_sync <= 2'h0;
    end else begin
      gate_meta <= external_interrupt_pin;
      gate_sync <= gate_meta;
    end
  end

  for (genvar gi = 0; gi < 3; gi++) begin : g_tmr
    localparam logic [7:0] CNT_ADDR = ADDR_COUNT0 + 8'(gi * 4);
    localparam logic [7:0] RLD_ADDR = ADDR_RELOAD0 + 8'(gi * 4);
    tpe_mode_type cfg;
    logic gate_ok;
    logic tick;
    logic step;
    logic down;
    logic ovf;
    logic [15:0] count;
    logic [15:0] reload;
    logic [15:0] next_count;
    logic flag;
    logic wave;

    // per-timer mode, timer 2 has no gate and runs in 16-bit reload mode
    if (gi < 2) begin : g_gate
      assign cfg = timer_mode_reg[gi];
      assign gate_ok = !cfg.gate || gate_sync[gi]; // see RULE14
      assign down = 1'b0;
    end else begin : g_updown
      assign cfg = '{gate: 1'b0, count_mode: timer_control_reg.count_mode2,
                     mode: MODE_RELOAD16};
      assign gate_ok = 1'b1;
      assign down = timer_control_reg.count_down; // see RULE1
    end

    // tick source and enable
    assign tick = cfg.count_mode ? fall[gi] : timer_base_clock; // see RULE13
    assign step = tick && timer_control_reg.run[gi] && gate_ok; // see RULE6

    // next count and overflow per mode
    always_comb begin
      next_count = count + 16'h0001; // see RULE3
      ovf = 1'b0;
      if (down) begin
        ovf = (count == 16'h0000); // see RULE1
        next_count = ovf ? reload : count - 16'h0001;
      end else begin
        case (cfg.mode)
          MODE_RELOAD16: begin
            ovf = (count == 16'hffff); // see RULE12
            if (ovf) begin
              next_count = reload;
            end
          end
          MODE_RELOAD8: begin
            ovf = (count[7:0] == 8'hff); // see RULE12
            next_count = {count[15:8], ovf ? reload[7:0] : count[7:0] + 8'h01};
          end
          default: begin
            ovf = (count == 16'hffff); // see RULE12
          end
        endcase
      end
    end

    // count register, software write wins over a tick
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        count <= COUNT_RESET;
      end else if (wr_en && wr_addr == CNT_ADDR) begin
        if (w_strb[0]) begin
          count[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          count[15:8] <= w_data[15:8];
        end
      end else if (step) begin
        count <= next_count; // see RULE3
      end
    end

    // reload register
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        reload <= COUNT_RESET;
      end else if (wr_en && wr_addr == RLD_ADDR) begin
        if (w_strb[0]) begin
          reload[7:0] <= w_data[7:0];
        end
        if (w_strb[1]) begin
          reload[15:8] <= w_data[15:8];
        end
      end
    end

    // sticky overflow flag, write one clears, set wins
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        flag <= 1'b0;
      end else if (step && ovf) begin
        flag <= 1'b1; // see RULE11
      end else if (wr_en && wr_addr == ADDR_STATUS && w_strb[0] && w_data[gi]) begin
        flag <= 1'b0;
      end
    end

    // toggle output on overflow
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        wave <= 1'b0;
      end else if (step && ovf && timer_control_reg.wave_en[gi]) begin
        wave <= ~wave; // see RULE11
      end
    end
  end

  assign timer_irq = {g_tmr[2].flag, g_tmr[1].flag, g_tmr[0].flag};
  assign timer_wave_out = {g_tmr[2].wave, g_tmr[1].wave, g_tmr[0].wave};

  // read mux, reads only look at state
  assign rd_addr = s_axi_araddr;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (rd_addr)
      ADDR_SYS_CFG: next_rdata[3:0] = system_config_reg;
      ADDR_TMR_MODE: next_rdata[7:0] = timer_mode_reg;
      ADDR_TMR_CTRL: next_rdata[7:0] = timer_control_reg;
      ADDR_STATUS: next_rdata[2:0] = timer_irq;
      ADDR_COUNT0: next_rdata[15:0] = g_tmr[0].count; // see RULE4
      ADDR_COUNT0 + ADDR_STRIDE: next_rdata[15:0] = g_tmr[1].count;
      ADDR_RELOAD0 - ADDR_STRIDE: next_rdata[15:0] = g_tmr[2].count;
      ADDR_RELOAD0: next_rdata[15:0] = g_tmr[0].reload;
      ADDR_RELOAD0 + ADDR_STRIDE: next_rdata[15:0] = g_tmr[1].reload;
      ADDR_LAST: next_rdata[15:0] = g_tmr[2].reload;
      default: next_rdata = 32'h0000_0000;
    endcase
  end

  // read channel, one read at a time
  assign s_axi_arready = !s_axi_rvalid;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= is_mapped(rd_addr) ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  chk_base_period: assert property ( // see RULE5
    timer_base_clock && system_config_reg.prescale == PSC_DIV4
    ##1 (system_config_reg.prescale == PSC_DIV4) [*4] |-> timer_base_clock)
    else $error("base tick period wrong at divide by four");

  chk_timer_step: assert property ( // see RULE6
    timer_base_clock && !g_tmr[0].cfg.count_mode && !g_tmr[0].cfg.gate
    && timer_control_reg.run[0] |-> g_tmr[0].step)
    else $error("timer 0 missed a base tick");

  chk_event_step: assert property ( // see RULE8
    fall[1] && g_tmr[1].cfg.count_mode && !g_tmr[1].cfg.gate && timer_control_reg.run[1]
    |-> g_tmr[1].step)
    else $error("timer 1 missed a count pin edge");

  chk_event_gap: assert property ( // see RULE9
    fall[0] |=> !fall[0])
    else $error("count pin sampled in consecutive cycles");

  chk_gate_block: assert property ( // see RULE14
    g_tmr[0].cfg.gate && !gate_sync[0] |-> !g_tmr[0].step)
    else $error("gated timer ran with gate pin low");

  chk_count_inc: assert property ( // see RULE3
    g_tmr[0].step && g_tmr[0].cfg.mode == MODE_FREE16 && !wr_en
    |=> g_tmr[0].count == 16'($past(g_tmr[0].count) + 16'h0001))
    else $error("timer 0 did not advance by one");

  chk_read_still: assert property ( // see RULE4
    s_axi_arvalid && s_axi_arready && !g_tmr[0].step && !wr_en
    |=> $stable(g_tmr[0].count))
    else $error("count read disturbed timer 0");

  chk_down_count: assert property ( // see RULE1
    g_tmr[2].step && g_tmr[2].down && g_tmr[2].count != 16'h0000 && !wr_en
    |=> g_tmr[2].count == 16'($past(g_tmr[2].count) - 16'h0001))
    else $error("timer 2 did not count down");

  chk_reload8: assert property ( // see RULE12
    g_tmr[0].step && g_tmr[0].cfg.mode == MODE_RELOAD8
    && g_tmr[0].count[7:0] == 8'hff && !wr_en
    |=> g_tmr[0].count[7:0] == $past(g_tmr[0].reload[7:0]))
    else $error("8-bit reload missed");

  chk_ovf_flag: assert property ( // see RULE11
    g_tmr[0].step && g_tmr[0].ovf |=> timer_irq[0] ##1 (timer_irq[0] || $past(wr_en)))
    else $error("overflow flag not held");

  cov_event_count: cover property (g_tmr[0].cfg.count_mode && g_tmr[0].step);
  cov_down_wrap: cover property (g_tmr[2].step && g_tmr[2].down && g_tmr[2].ovf);
  cov_wave_toggle: cover property ($changed(timer_wave_out));
  cov_div64_tick: cover property (timer_base_clock && system_config_reg.prescale == PSC_DIV64);
endmodule : tpe_timer_top

// file: dv/tpe_pin_model.sv
// Purpose: board-side driver of the count pins and the gate pins
// Assumes: pins change right after a rising edge of aclk
// Notes: count pins idle high, gate pins idle low
`timescale 1ns/1ps
module tpe_pin_model (
  input wire logic aclk,
  output logic [2:0] count_input_pin,
  output logic [1:0] external_interrupt_pin
);
  // idle levels from time zero
  initial begin
    count_input_pin = 3'h7;
    external_interrupt_pin = 2'h0;
  end
  // n falling edges, each level held for hold cycles
  task automatic pulses(input int pin, input int n, input int hold);
    for (int i = 0; i < n; i++) begin
      count_input_pin[pin] <= 1'b0;
      repeat (hold) @(posedge aclk);
      count_input_pin[pin] <= 1'b1;
      repeat (hold) @(posedge aclk);
    end
  endtask : pulses
  // gate levels for timers 0 and 1
  task automatic set_gate(input logic [1:0] lvl);
    external_interrupt_pin <= lvl;
  endtask : set_gate
endmodule : tpe_pin_model

// file: dv/tb.sv
// Purpose: self-checking bench of the timer prescale and event count block
// Assumes: aclk is the oscillator at 40 MHz
// Notes: counts are read over the register bus, pins come from the board model
`timescale 1ns/1ps
module tb;
  import tpe_pkg::*;
  logic aclk, aresetn, timer_base_clock, wave, o;
  logic [7:0] s_axi_awaddr, s_axi_araddr, ad;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, external_interrupt_pin, resp;
  logic [2:0] count_input_pin, timer_irq, timer_wave_out;
  logic [15:0] v, e;
  int n_errors = 0;
  int n_checks = 0;
  int seed = 32'h8e7fbe9b;
  int ticks = 0;
  int n, a, b, t;
  real t0;

  tpe_timer_top u_tpe_timer_top (.*);
  tpe_pin_model u_tpe_pin_model (
    .aclk(aclk),
    .count_input_pin(count_input_pin),
    .external_interrupt_pin(external_interrupt_pin)
  );

  // oscillator
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  // base ticks counted where they are settled
  always @(negedge aclk) begin
    if (timer_base_clock === 1'b1) ticks++;
  end

  task automatic check(input string w, input logic [31:0] seen, input logic [31:0] ex);
    n_checks++;
    if (seen !== ex) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", w, ex, seen);
    end
  endtask : check
  // one write, handshakes judged on values held before the edge
  task automatic wr(input logic [7:0] ad_w, input logic [31:0] d);
    logic aw, w, bv;
    s_axi_awaddr <= ad_w;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do begin
      @(negedge aclk);
      aw = s_axi_awvalid & s_axi_awready;
      w = s_axi_wvalid & s_axi_wready;
      bv = s_axi_bvalid;
      resp = s_axi_bresp;
      @(posedge aclk);
      if (aw) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
    end while (!bv);
  endtask : wr
  // one read
  task automatic rd(input logic [7:0] ad_r);
    logic ar, rv;
    s_axi_araddr <= ad_r;
    s_axi_arvalid <= 1'b1;
    do begin
      @(negedge aclk);
      ar = s_axi_arvalid & s_axi_arready;
      rv = s_axi_rvalid;
      rdat = s_axi_rdata;
      resp = s_axi_rresp;
      @(posedge aclk);
      if (ar) s_axi_arvalid <= 1'b0;
    end while (!rv);
  endtask : rd
  task automatic rchk(input string w, input logic [7:0] ad_c, input logic [31:0] ex);
    rd(ad_c);
    check(w, rdat, ex);
    check("rresp", 32'(resp), 32'(RESP_OKAY));
  endtask : rchk
  function automatic int period(input int c);
    return c == 0 ? DIV4 : c == 1 ? DIV16 : DIV64;
  endfunction : period
  // next count after one step in modes of timers 0 and 1
  function automatic logic [15:0] nxt(input logic [1:0] m, input logic [15:0] c,
                                      input logic [15:0] rl);
    if (m == MODE_RELOAD8 && c[7:0] == 8'hff) return {c[15:8], rl[7:0]};
    if (m == MODE_RELOAD16 && c == 16'hffff) return rl;
    return c + 16'h0001;
  endfunction : nxt
  task automatic conclude;
    if (n_errors == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude

  // cut a hang short
  initial begin
    #(25.0 * 40000);
    n_errors++;
    conclude();
  end

  initial begin
    aresetn = 1'b0;
    s_axi_awaddr = 8'h00;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hf;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b1;
    s_axi_araddr = 8'h00;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    // counts start at zero, unmapped places answer an error
    for (int i = 0; i < 3; i++) begin
      rchk("count rst", ADDR_COUNT0 + 8'(4 * i), 32'(COUNT_RESET));
    end
    rd(ADDR_LAST + 8'h04);
    check("unmapped rresp", 32'(resp), 32'(RESP_SLVERR));
    check("unmapped rdata", rdat, 32'h0);
    wr(8'h02, 32'hffff);
    check("misaligned bresp", 32'(resp), 32'(RESP_SLVERR));
    // base tick spacing for every prescale code
    for (int c = 0; c < 4; c++) begin
      wr(ADDR_SYS_CFG, 32'(c) << 2);
      t = ticks;
      wait (ticks == t + 2);
      t0 = $realtime;
      wait (ticks == t + 3);
      check("base period", int'(($realtime - t0) / 25.0), period(c));
      @(posedge aclk);
    end
    // all timers step on the shared base while being read
    wr(ADDR_SYS_CFG, 32'(PSC_DIV4) << 2);
    wr(ADDR_TMR_MODE, 32'h11);
    wr(ADDR_TMR_CTRL, 32'h07);
    for (int i = 0; i < 6; i++) begin
      ad = ADDR_COUNT0 + 8'(4 * (i % 3));
      rd(ad);
      a = rdat[15:0];
      t = ticks;
      repeat (20 + $unsigned($random(seed)) % 80) @(posedge aclk);
      rd(ad);
      n = ticks - t;
      b = 16'(rdat[15:0] - a[15:0]);
      check("timer steps", 32'(b >= n - 1 && b <= n + 1), 32'h1);
    end
    // falling pin edges step each timer in event mode
    wr(ADDR_TMR_MODE, 32'h55);
    wr(ADDR_TMR_CTRL, 32'h0f);
    for (int i = 0; i < 6; i++) begin
      ad = ADDR_COUNT0 + 8'(4 * (i % 3));
      v = 16'($random(seed)) & 16'h0fff;
      n = 1 + $unsigned($random(seed)) % 5;
      wr(ad, 32'(v));
      u_tpe_pin_model.pulses(i % 3, n, 2 + $unsigned($random(seed)) % 3);
      repeat (8) @(posedge aclk);
      rchk("event count", ad, 32'(v) + 32'(n));
    end
    // gate pin low holds timer 0, high lets it count
    wr(ADDR_TMR_MODE, 32'h5d);
    for (int g = 0; g < 2; g++) begin
      u_tpe_pin_model.set_gate(2'(g));
      wr(ADDR_COUNT0, 32'h0);
      u_tpe_pin_model.pulses(0, 3, 2);
      repeat (8) @(posedge aclk);
      rchk("gated count", ADDR_COUNT0, 32'(3 * g));
    end
    // every mode at byte and word boundary, flag and toggle on overflow
    wr(ADDR_RELOAD0, 32'h1234);
    wr(ADDR_TMR_CTRL, 32'h2f);
    wave = timer_wave_out[0];
    for (int m = 0; m < 4; m++) begin
      for (int k = 0; k < 2; k++) begin
        v = k ? 16'hffff : 16'h00ff;
        e = nxt(2'(m), v, 16'h1234);
        o = (m == 2) ? (v[7:0] == 8'hff) : (v == 16'hffff);
        wave = wave ^ o;
        wr(ADDR_TMR_MODE, 32'h54 | 32'(m));
        wr(ADDR_COUNT0, 32'(v));
        u_tpe_pin_model.pulses(0, 1, 2);
        repeat (8) @(posedge aclk);
        rchk("mode step", ADDR_COUNT0, 32'(e));
        check("overflow flag", 32'(timer_irq[0]), 32'(o));
        check("toggle out", 32'(timer_wave_out[0]), 32'(wave));
        wr(ADDR_STATUS, 32'h1);
        check("flag clear", 32'(timer_irq[0]), 32'h0);
      end
    end
    // timer 2 counts down and reloads after zero
    wr(ADDR_RELOAD0 + 8'h08, 32'h0042);
    wr(ADDR_TMR_CTRL, 32'h1f);
    wr(ADDR_COUNT0 + 8'h08, 32'h0002);
    u_tpe_pin_model.pulses(2, 3, 2);
    repeat (8) @(posedge aclk);
    rchk("down count", ADDR_COUNT0 + 8'h08, 32'h0042);
    check("down flag", 32'(timer_irq[2:1]), 32'h2);
    check("toggle rest", 32'(timer_wave_out[2:1]), 32'h0);
    conclude();
  end
endmodule : tb
